// ---- logic/irq_params.svh ----
// Register offsets, field positions, reset values and timing counts of the interrupt aggregator.
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define GRP_STRIDE 8'h03
`define GRP_STATUS_OFS 8'h00
`define GRP_MASK_OFS 8'h01
`define GRP_LEVEL_OFS 8'h02
`define GROUP4_RISE_SELECT_ADDR 8'h0c
`define GROUP4_FALL_SELECT_ADDR 8'h0d
`define IRQ_CTRL_ADDR 8'h0e
`define OSC_THERMAL_CONFIG_ADDR 8'h0f
`define SECONDARY_EVENT_CONFIG_ADDR 8'h10
`define LONG_HOLD_DELAY_ADDR 8'h11

// ==========================================================================
// Fields
// ==========================================================================
`define CTRL_POLARITY_HIGH_BIT 0
`define CTRL_CLEAR_ON_WRITE_BIT 1
`define CTRL_PENDING_EN_BIT 2
`define OSC_MASK_IN_SLEEP_BIT 0
`define SEC_FIRST_SUPPLY_SELECT_BIT 0
`define G1_SUPPLY_MON_BIT 6
`define G1_DIE_OVERTEMP_BIT 5
`define G1_POWER_DOWN_BIT 4
`define G1_LONG_HOLD_BIT 2
`define G1_POWER_BUTTON_BIT 1
`define G2_REG_SHORT_BIT 6
`define G2_FIRST_SUPPLY_BIT 5
`define G2_RESET_IN_BIT 4
`define G2_WATCHDOG_BIT 2

// ==========================================================================
// Reset values and fixed edge selections
// ==========================================================================
`define MASK_RESET 8'h00
`define RISE_SELECT_RESET 8'hff
`define FALL_SELECT_RESET 8'h00
`define CTRL_RESET 3'h0
`define OSC_THERMAL_CONFIG_RESET 1'b0
`define SECONDARY_EVENT_CONFIG_RESET 1'b1
`define LONG_HOLD_DELAY_RESET 8'h08
`define G1_RISE_EDGES 8'h70
`define G1_FALL_EDGES 8'h72
`define G2_RISE_EDGES 8'h74
`define G3_RISE_EDGES 8'hff

// ==========================================================================
// Timing
// ==========================================================================
`define REF_CLK_MHZ 25
`define LONG_HOLD_UNIT_US 1000
`define LONG_HOLD_UNIT_CYCLES (`LONG_HOLD_UNIT_US * `REF_CLK_MHZ)

`endif

// ---- logic/irq_pkg.sv ----
// Types shared by the interrupt aggregator and its edge detector.
package irq_pkg;

	typedef enum logic [2:0] {
		PWR_OFF = 3'b001,
		PWR_SLEEP = 3'b010,
		PWR_ACTIVE = 3'b100
	} pwr_state_e;

	typedef struct packed {
		logic [31:0] meta;
		logic [31:0] level;
		logic [31:0] prev;
	} edges_state_s;

	typedef struct packed {
		logic [3:0][7:0] status;
		logic [3:0][7:0] pending;
		logic [3:0][7:0] mask;
		logic [7:0] rise_sel;
		logic [7:0] fall_sel;
		logic [2:0] ctrl;
		logic osc_cfg;
		logic sec_cfg;
		logic [7:0] hold_delay;
		logic [15:0] tick_cnt;
		logic [7:0] hold_units;
		logic hold_fired;
		logic [7:0] last_addr;
		logic last_valid;
		logic [7:0] rdata;
		logic line_active;
		logic int_pin;
		logic on_req;
	} irq_state_s;

endpackage : irq_pkg

// ---- logic/source_edges.sv ----
// Two-stage capture of all source lines with single-cycle rising and falling pulses.
module source_edges (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] lines,
	output logic [31:0] level,
	output logic [31:0] rise,
	output logic [31:0] fall
);

	irq_pkg::edges_state_s q;
	irq_pkg::edges_state_s d;

	// The first stage only feeds the second, so edges are taken from settled copies.
	always_comb begin
		d = q;
		d.meta = lines;
		d.level = q.meta;
		d.prev = q.level;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.level;
	// One pulse per qualifying edge, however long the new level lasts.
	assign rise = q.level & ~q.prev;
	assign fall = ~q.level & q.prev;

endmodule : source_edges

// ---- logic/irq_aggregator.sv ----
// Interrupt aggregator: four event groups, status clearing, pending storage and host interrupt pin.
`include "irq_params.svh"

module irq_aggregator #(
	parameter int LONG_HOLD_UNIT_CYCLES = `LONG_HOLD_UNIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire irq_pkg::pwr_state_e power_state,
	input wire logic supply_voltage_monitor,
	input wire logic die_overtemp,
	input wire logic power_down_pin,
	input wire logic power_button_n,
	input wire logic regulator_short,
	input wire logic first_supply_detect,
	input wire logic reset_in_pin,
	input wire logic watchdog_expiry,
	input wire logic [7:0] group3_src,
	input wire logic [7:0] group4_src,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic host_int,
	output logic sleep_hold,
	output logic on_request
);

	// ==========================================================================
	// Source capture
	// ==========================================================================
	logic [31:0] lines;
	logic [31:0] level;
	logic [31:0] rise;
	logic [31:0] fall;

	assign lines = {group4_src, group3_src,
		1'b0, regulator_short, first_supply_detect, reset_in_pin, 1'b0, watchdog_expiry, 2'b00,
		1'b0, supply_voltage_monitor, die_overtemp, power_down_pin, 1'b0, power_button_n, power_button_n, 1'b0};

	source_edges edges_u (
		.ref_clk(ref_clk),
		.srst(srst),
		.lines(lines),
		.level(level),
		.rise(rise),
		.fall(fall)
	);

	// ==========================================================================
	// State
	// ==========================================================================
	irq_pkg::irq_state_s q;
	irq_pkg::irq_state_s d;

	logic [31:0] rise_sel_all;
	logic [31:0] fall_sel_all;
	logic [3:0][7:0] detected;
	logic [3:0][7:0] events;
	logic [3:0][7:0] clr;
	logic [3:0][7:0] st_c;
	logic [3:0][7:0] pd_c;
	logic in_run;
	logic clear_ok;
	logic hold_tick;
	logic button_low;
	logic long_hold_pulse;
	logic press_pulse;
	logic any_latched;
	logic on_capable;
	logic pin_allowed;

	// Fixed edges for groups one to three, software choice for group four.
	assign rise_sel_all = {q.rise_sel, `G3_RISE_EDGES, `G2_RISE_EDGES, `G1_RISE_EDGES};
	assign fall_sel_all = {q.fall_sel, 8'h00, 8'h00, `G1_FALL_EDGES};

	assign in_run = (power_state == irq_pkg::PWR_ACTIVE) || (power_state == irq_pkg::PWR_SLEEP);
	assign button_low = ~level[`G1_POWER_BUTTON_BIT];
	assign hold_tick = (32'(q.tick_cnt) == LONG_HOLD_UNIT_CYCLES - 1);
	assign long_hold_pulse = hold_tick && button_low && !q.hold_fired && (q.hold_units == q.hold_delay);
	assign press_pulse = fall[`G1_POWER_BUTTON_BIT] && in_run;

	// A clearing access right after an access to the same register has no effect.
	assign clear_ok = !(q.last_valid && (q.last_addr == reg_addr));

	// ==========================================================================
	// Event qualification
	// ==========================================================================
	always_comb begin
		detected = (rise & rise_sel_all) | (fall & fall_sel_all);
		detected[0][`G1_LONG_HOLD_BIT] = long_hold_pulse;
		detected[0][`G1_POWER_BUTTON_BIT] = press_pulse;
		detected[0][`G1_DIE_OVERTEMP_BIT] = detected[0][`G1_DIE_OVERTEMP_BIT] && in_run;
		detected[1][`G2_FIRST_SUPPLY_BIT] = detected[1][`G2_FIRST_SUPPLY_BIT] && q.sec_cfg;
		// A masked source is still detected, but nothing is latched or kept.
		events = detected & ~q.mask;
	end

	// ==========================================================================
	// Status, pending and clearing
	// ==========================================================================
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			clr[g] = 8'h00;
			if (reg_addr == 8'(g * 3) + `GRP_STATUS_OFS && clear_ok) begin
				if (reg_rd_en && !q.ctrl[`CTRL_CLEAR_ON_WRITE_BIT]) begin
					clr[g] = 8'hff;
				end else if (reg_wr_en && q.ctrl[`CTRL_CLEAR_ON_WRITE_BIT]) begin
					clr[g] = reg_wdata;
				end
			end
			// A cleared bit with a stored repeat takes that repeat as its new event.
			st_c[g] = (q.status[g] & ~clr[g]) | (q.pending[g] & clr[g]);
			pd_c[g] = q.pending[g] & ~clr[g];
		end
	end

	assign any_latched = |(q.status & ~q.mask);
	assign on_capable = |(q.status[1][6:5] & ~q.mask[1][6:5]) | |(q.status[2] & ~q.mask[2])
		| |(q.status[3] & ~q.mask[3]);
	assign pin_allowed = !((power_state == irq_pkg::PWR_SLEEP) && q.osc_cfg);

	always_comb begin
		d = q;

		// Events are applied after the clear, so an event in the clearing cycle survives.
		for (int g = 0; g < 4; g++) begin
			d.status[g] = st_c[g] | events[g];
			if (q.ctrl[`CTRL_PENDING_EN_BIT] && q.line_active) begin
				d.pending[g] = pd_c[g] | (events[g] & st_c[g]);
			end else begin
				d.pending[g] = pd_c[g];
			end
			if (reg_wr_en && reg_addr == 8'(g * 3) + `GRP_MASK_OFS) begin
				d.mask[g] = reg_wdata;
			end
		end

		if (reg_wr_en) begin
			unique case (reg_addr)
				`GROUP4_RISE_SELECT_ADDR: d.rise_sel = reg_wdata;
				`GROUP4_FALL_SELECT_ADDR: d.fall_sel = reg_wdata;
				`IRQ_CTRL_ADDR: d.ctrl = reg_wdata[2:0];
				`OSC_THERMAL_CONFIG_ADDR: d.osc_cfg = reg_wdata[`OSC_MASK_IN_SLEEP_BIT];
				`SECONDARY_EVENT_CONFIG_ADDR: d.sec_cfg = reg_wdata[`SEC_FIRST_SUPPLY_SELECT_BIT];
				`LONG_HOLD_DELAY_ADDR: d.hold_delay = reg_wdata;
				default: d.rise_sel = q.rise_sel;
			endcase
		end

		// Read data reflects the value before any clear caused by the same read.
		if (reg_rd_en) begin
			d.rdata = 8'h00;
			for (int g = 0; g < 4; g++) begin
				if (reg_addr == 8'(g * 3) + `GRP_STATUS_OFS) begin
					d.rdata = q.status[g];
				end
				if (reg_addr == 8'(g * 3) + `GRP_MASK_OFS) begin
					d.rdata = q.mask[g];
				end
				if (reg_addr == 8'(g * 3) + `GRP_LEVEL_OFS) begin
					d.rdata = level[g * 8 +: 8];
				end
			end
			unique case (reg_addr)
				`GROUP4_RISE_SELECT_ADDR: d.rdata = q.rise_sel;
				`GROUP4_FALL_SELECT_ADDR: d.rdata = q.fall_sel;
				`IRQ_CTRL_ADDR: d.rdata = {5'h00, q.ctrl};
				`OSC_THERMAL_CONFIG_ADDR: d.rdata = {7'h00, q.osc_cfg};
				`SECONDARY_EVENT_CONFIG_ADDR: d.rdata = {7'h00, q.sec_cfg};
				`LONG_HOLD_DELAY_ADDR: d.rdata = q.hold_delay;
				default: d.rdata = d.rdata;
			endcase
		end

		if (reg_rd_en || reg_wr_en) begin
			d.last_addr = reg_addr;
			d.last_valid = 1'b1;
		end

		// ======================================================================
		// Long-hold timing
		// ======================================================================
		// The unit divider free-runs; the first unit may be short by up to one unit.
		d.tick_cnt = hold_tick ? 16'h0000 : q.tick_cnt + 16'h0001;
		if (!button_low) begin
			d.hold_units = 8'h00;
			d.hold_fired = 1'b0;
		end else if (hold_tick) begin
			if (long_hold_pulse) begin
				d.hold_fired = 1'b1;
			end else if (!q.hold_fired) begin
				d.hold_units = q.hold_units + 8'h01;
			end
		end

		// ======================================================================
		// Outputs
		// ======================================================================
		// Masked bits that stay latched are not counted, so masking quiets the pin.
		d.line_active = |(d.status & ~d.mask);
		d.int_pin = (d.line_active && pin_allowed) ~^ q.ctrl[`CTRL_POLARITY_HIGH_BIT];
		// Any unmasked latched event in any group asks for power-on, as does a button press in the active or sleep state.
		d.on_req = on_capable || any_latched || press_pulse;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '0;
			q.mask <= {4{`MASK_RESET}};
			q.rise_sel <= `RISE_SELECT_RESET;
			q.fall_sel <= `FALL_SELECT_RESET;
			q.ctrl <= `CTRL_RESET;
			q.osc_cfg <= `OSC_THERMAL_CONFIG_RESET;
			q.sec_cfg <= `SECONDARY_EVENT_CONFIG_RESET;
			q.hold_delay <= `LONG_HOLD_DELAY_RESET;
			q.int_pin <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign host_int = q.int_pin;
	// The sequencer must not enter sleep while any unmasked event stays latched.
	assign sleep_hold = q.line_active;
	assign on_request = q.on_req;

endmodule : irq_aggregator

// ---- bench/irq_aggregator_props.sv ----
// Port-level assertions of the interrupt aggregator and their bind.
`include "irq_params.svh"

module irq_aggregator_props (
	input wire logic ref_clk,
	input wire logic srst,
	input wire irq_pkg::pwr_state_e power_state,
	input wire logic power_down_pin,
	input wire logic power_button_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic host_int,
	input wire logic sleep_hold,
	input wire logic on_request
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// ==========================================================================
	// Configuration shadow
	// Polarity and sleep gating change what the pin means, so they are shadowed from writes.
	logic pol_q;
	logic msk_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pol_q <= 1'b0;
			msk_q <= 1'b0;
		end else if (reg_wr_en && reg_addr == `IRQ_CTRL_ADDR) begin
			pol_q <= reg_wdata[`CTRL_POLARITY_HIGH_BIT];
		end else if (reg_wr_en && reg_addr == `OSC_THERMAL_CONFIG_ADDR) begin
			msk_q <= reg_wdata[`OSC_MASK_IN_SLEEP_BIT];
		end
	end

	// ==========================================================================
	// Properties
	sequence pin_steady;
		$stable(power_down_pin) [*4];
	endsequence
	sequence delay_write_read;
		reg_wr_en && reg_addr == `LONG_HOLD_DELAY_ADDR ##2 reg_rd_en && reg_addr == `LONG_HOLD_DELAY_ADDR;
	endsequence

	AST_RESET_IDLE: assert property ($fell(srst) |-> host_int && !sleep_hold && !on_request)
		else $error("outputs not idle after reset");
	AST_UNMAPPED: assert property (reg_rd_en && reg_addr > `LONG_HOLD_DELAY_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_PIN_FOLLOWS: assert property (power_state == irq_pkg::PWR_ACTIVE && $stable(power_state) && $stable(pol_q)
		|-> host_int == (sleep_hold ~^ pol_q)) else $error("pin disagrees with latched events");
	AST_SLEEP_BLOCK: assert property (power_state == irq_pkg::PWR_SLEEP && $stable(power_state) && msk_q
		&& $stable(msk_q) && $stable(pol_q) |-> host_int == !pol_q) else $error("pin active in masked sleep");
	AST_LEVEL: assert property (pin_steady ##0 reg_rd_en && reg_addr == `GRP_LEVEL_OFS
		|=> reg_rdata[`G1_POWER_DOWN_BIT] == $past(power_down_pin)) else $error("live level wrong");
	AST_DELAY_READBACK: assert property (delay_write_read |=> reg_rdata == $past(reg_wdata, 3))
		else $error("hold delay readback wrong");
	AST_PRESS_REQ: assert property ($fell(power_button_n) && power_state == irq_pkg::PWR_ACTIVE
		|-> ##[1:5] on_request) else $error("press gave no on request");
endmodule : irq_aggregator_props

bind irq_aggregator irq_aggregator_props irq_aggregator_props_i (.*);

// ---- bench/host_model.sv ----
// Host processor model: single register accesses and the interrupt service loop.
module host_model (
	input wire logic ref_clk,
	input wire logic host_int,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 8'h00;
	end

	// ==========================================================================
	// Access
	// Released lines show the inverse of the last value so a stale address cannot pass.
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = w;
		reg_rd_en = !w;
		@(posedge ref_clk);
		#1;
		q = reg_rdata;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : acc

	// Clears all four groups and repeats while the pin stays active, four passes at most.
	task service(input logic cow, input logic pol, output int passes);
		logic [7:0] q;
		passes = 0;
		while (host_int == pol && passes < 4) begin
			for (int g = 0; g < 4; g++) begin
				acc(cow, 8'(3 * g), 8'hff, q);
			end
			passes++;
			repeat (3) @(posedge ref_clk);
		end
	endtask : service
endmodule : host_model

// ---- bench/pmic_irq_aggregator_tb.sv ----
// Self-checking bench of the interrupt aggregator driven through the host model.
`include "irq_params.svh"

module pmic_irq_aggregator_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int UNIT = 8;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	irq_pkg::pwr_state_e power_state = irq_pkg::PWR_ACTIVE;
	logic [7:0] s [4] = '{8'h02, 8'h00, 8'h00, 8'h00};
	logic [7:0] o [4];
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] r;
	logic reg_wr_en;
	logic reg_rd_en;
	logic host_int;
	logic sleep_hold;
	logic on_request;
	int mismatches = 0;
	int tests_run = 0;
	int seed = 35106;
	int passes;

	always #20 ref_clk = ~ref_clk;

	irq_aggregator #(.LONG_HOLD_UNIT_CYCLES(UNIT)) irq_aggregator_i (
		.ref_clk(ref_clk), .srst(srst), .power_state(power_state),
		.supply_voltage_monitor(s[0][6]), .die_overtemp(s[0][5]), .power_down_pin(s[0][4]),
		.power_button_n(s[0][1]), .regulator_short(s[1][6]), .first_supply_detect(s[1][5]),
		.reset_in_pin(s[1][4]), .watchdog_expiry(s[1][2]), .group3_src(s[2]), .group4_src(s[3]),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .host_int(host_int), .sleep_hold(sleep_hold), .on_request(on_request)
	);

	host_model host_model_i (
		.ref_clk(ref_clk), .host_int(host_int), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata)
	);

	// ==========================================================================
	// Helpers
	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (e !== g) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task pin(input logic e);
		chk("host_int", {7'h00, e}, {7'h00, host_int});
	endtask : pin

	task tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tk

	task wr(input logic [7:0] a, input logic [7:0] d);
		host_model_i.acc(1'b1, a, d, r);
	endtask : wr

	task flip(input logic [7:0] m);
		s[0] = s[0] ^ m;
		tk(4);
	endtask : flip

	// Upper byte nonzero means a write of that byte; otherwise a read checked against e.
	task run(input logic [15:0] op[$], input logic [7:0] e[$]);
		foreach (op[i]) begin
			if (op[i][15:8] != 8'h00) begin
				wr(op[i][7:0], op[i][15:8]);
			end else begin
				host_model_i.acc(1'b0, op[i][7:0], 8'h00, r);
				chk("register", e[i], r);
			end
		end
	endtask : run

	function automatic logic [7:0] expect_status(input int g, input logic [7:0] a, input logic [7:0] b);
		if (g == 0) begin
			return ((a ^ b) & 8'h70) | (a & ~b & 8'h02);
		end
		return ~a & b & (g == 1 ? 8'h74 : 8'hff);
	endfunction : expect_status

	// ==========================================================================
	// Sequence
	initial begin
		tk(20);
		srst = 1'b0;
		tk(3);
		run('{16'h0001, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h0010, 16'h0011, 16'h0020},
			'{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00});
		for (int i = 0; i < 8; i++) begin
			o = s;
			s[0] = (8'($random(seed)) & 8'h70) | 8'h02;
			s[1] = 8'($random(seed)) & 8'h54;
			s[2] = 8'($random(seed));
			s[3] = 8'($random(seed));
			tk(4);
			for (int g = 0; g < 4; g++) begin
				host_model_i.acc(1'b0, 8'(3 * g), 8'h00, r);
				chk("status", expect_status(g, o[g], s[g]), r);
			end
			run('{16'h0002}, '{(s[0] & 8'h70) | 8'h06});
		end
		pin(1'b1);
		wr(`GRP_MASK_OFS, 8'h10);
		flip(8'h10);
		pin(1'b1);
		wr(`GRP_MASK_OFS, 8'h00);
		flip(8'h40);
		wr(`GRP_MASK_OFS, 8'h40);
		tk(2);
		run('{16'h0000, 16'h0003, 16'h0000}, '{8'h40, 8'h00, 8'h00});
		wr(`GRP_MASK_OFS, 8'h00);
		wr(`IRQ_CTRL_ADDR, 8'h04);
		repeat (3) flip(8'h10);
		run('{16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0003, 16'h0000},
			'{8'h10, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00});
		wr(`IRQ_CTRL_ADDR, 8'h00);
		repeat (2) flip(8'h10);
		run('{16'h0000, 16'h0003, 16'h0000}, '{8'h10, 8'h00, 8'h00});
		wr(`IRQ_CTRL_ADDR, 8'h02);
		flip(8'h50);
		run('{16'h0000, 16'h0003, 16'h1000, 16'h0000, 16'h0003, 16'hff00, 16'h0003, 16'h0000},
			'{8'h50, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00});
		wr(`IRQ_CTRL_ADDR, 8'h01);
		tk(3);
		pin(1'b0);
		wr(`OSC_THERMAL_CONFIG_ADDR, 8'h01);
		power_state = irq_pkg::PWR_SLEEP;
		flip(8'h40);
		pin(1'b0);
		chk("sleep_hold", 8'h01, {7'h00, sleep_hold});
		chk("on_request", 8'h01, {7'h00, on_request});
		power_state = irq_pkg::PWR_ACTIVE;
		tk(2);
		pin(1'b1);
		host_model_i.service(1'b0, 1'b1, passes);
		pin(1'b0);
		wr(`IRQ_CTRL_ADDR, 8'h00);
		wr(`OSC_THERMAL_CONFIG_ADDR, 8'h00);
		wr(`LONG_HOLD_DELAY_ADDR, 8'h02);
		run('{16'h0011}, '{8'h02});
		s[0][1] = 1'b0;
		tk(40);
		s[0][1] = 1'b1;
		tk(4);
		run('{16'h0000, 16'h0003, 16'h0000}, '{8'h06, 8'h00, 8'h00});
		wr(`GRP_MASK_OFS, 8'h02);
		flip(8'h02);
		flip(8'h02);
		wr(`GRP_MASK_OFS, 8'h00);
		power_state = irq_pkg::PWR_OFF;
		flip(8'h22);
		flip(8'h02);
		power_state = irq_pkg::PWR_ACTIVE;
		tk(2);
		run('{16'h0000, 16'h0003, 16'h0000}, '{8'h00, 8'h00, 8'h00});
		s[3] = 8'h00;
		tk(4);
		host_model_i.service(1'b0, 1'b0, passes);
		wr(`GROUP4_RISE_SELECT_ADDR, 8'h00);
		wr(`GROUP4_FALL_SELECT_ADDR, 8'h01);
		s[3] = 8'h01;
		tk(4);
		s[3] = 8'h00;
		tk(4);
		run('{16'h0009}, '{8'h01});
		stop_test();
	end

	// The sequence needs under 500 cycles; this limit of 5000 cycles leaves ample margin.
	initial begin
		#(40 * 5000);
		mismatches++;
		stop_test();
	end
endmodule : pmic_irq_aggregator_tb
